// ==== rtl/irq_pkg.sv ====
// shared constants, types and decode helpers for the interrupt sequencer
package irq_pkg;
   // ----------------------------------------
   // sizes and sources
   // ----------------------------------------
   localparam int PC_W = 13;
   localparam int SRC_N = 4;
   localparam int ADDR_W = 8;
   localparam logic [1:0] SRC_EXT = 2'h0;
   localparam logic [1:0] SRC_T0 = 2'h1;
   localparam logic [1:0] SRC_ADC = 2'h2;
   localparam logic [1:0] SRC_TB = 2'h3;
   localparam logic [PC_W-1:0] VEC_BASE = 13'h0004;
   localparam logic [PC_W-1:0] VEC_STEP = 13'h0004;

   // ----------------------------------------
   // register map and fields
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CTRL_A = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CTRL_B = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_EDGE = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STAT = 8'h0c;
   localparam int A_GIE = 0;
   localparam int A_EXT_EN = 1;
   localparam int A_T0_EN = 2;
   localparam int A_ADC_EN = 3;
   localparam int A_EXT_F = 4;
   localparam int A_T0_F = 5;
   localparam int A_ADC_F = 6;
   localparam int B_TB_EN = 0;
   localparam int B_TB_F = 4;
   localparam int EDGE_LO = 6;
   localparam int EDGE_HI = 7;
   localparam int ST_STATE_LSB = 0;
   localparam int ST_SRC_LSB = 4;
   localparam int ST_WAKE_BIT = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------
   // enumerations
   // ----------------------------------------
   typedef enum logic [1:0] {
      EDGE_OFF = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_FALL = 2'b10,
      EDGE_BOTH = 2'b11
   } edge_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAKE = 2'b01,
      ST_PUSH = 2'b10,
      ST_LOAD = 2'b11
   } seq_state_t;

   // ----------------------------------------
   // cpu side carriers
   // ----------------------------------------
   typedef struct packed {
      logic boundary;
      logic sleep;
      logic stack_full;
      logic interrupt_return_instruction;
      logic [PC_W-1:0] pc;
   } cpu_req_t;

   typedef struct packed {
      logic push;
      logic pop;
      logic load;
      logic [PC_W-1:0] push_addr;
      logic [PC_W-1:0] vector_addr;
   } cpu_ctl_t;

   // vector address of a source index
   function automatic logic [PC_W-1:0] vector_of(input logic [1:0] idx);
      vector_of = VEC_BASE + PC_W'({idx, 2'b00});
   endfunction
endpackage

// ==== rtl/ext_edge_detect.sv ====
// external pin synchroniser and selectable edge detector
`timescale 1ns/1ps
module ext_edge_detect import irq_pkg::*; (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // pin and mode
   input wire logic pin_in,
   input wire edge_mode_t mode_in,
   // detected edge
   output logic edge_out
);
   logic sync1_reg;
   logic sync2_reg;
   logic prev_reg;
   logic rise;
   logic fall;

   // two-stage synchroniser then history flop
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else if (ce_in) begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   // edge select decode
   assign rise = sync2_reg & ~prev_reg;
   assign fall = ~sync2_reg & prev_reg;
   always_comb begin
      unique case (mode_in)
         EDGE_OFF: edge_out = 1'b0;
         EDGE_RISE: edge_out = rise;
         EDGE_FALL: edge_out = fall;
         EDGE_BOTH: edge_out = rise | fall;
      endcase
   end
endmodule

// ==== rtl/irq_priority_pick.sv ====
// fixed priority pick among pending enabled sources
`timescale 1ns/1ps
module irq_priority_pick import irq_pkg::*; (
   // pending and enabled requests
   input wire logic [SRC_N-1:0] req_in,
   // winner
   output logic valid_out,
   output logic [1:0] idx_out
);
   // lowest index wins, scanning down so it overrides
   always_comb begin
      valid_out = 1'b0;
      idx_out = SRC_EXT;
      for (int i = SRC_N - 1; i >= 0; i--) begin
         if (req_in[i]) begin
            valid_out = 1'b1;
            idx_out = 2'(i);
         end
      end
   end
endmodule

// ==== rtl/mcu_interrupt_sequencer.sv ====
// interrupt flags, enables, sequencing and register slave
`timescale 1ns/1ps
module mcu_interrupt_sequencer import irq_pkg::*; (
   // clock, reset, enable
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // event sources
   input wire logic ext_pin_in,
   input wire logic t0_overflow_in,
   input wire logic adc_done_in,
   input wire logic tb_event_in,
   // cpu core
   input wire cpu_req_t cpu_req_in,
   output cpu_ctl_t cpu_ctl_out,
   output logic wake_out,
   // axi4-lite slave
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic gie_reg;
   logic [SRC_N-1:0] en_reg;
   logic [SRC_N-1:0] flag_reg;
   logic [SRC_N-1:0] flag_next;
   edge_mode_t edge_reg;
   seq_state_t state_reg;
   logic [1:0] src_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic aw_have_reg;
   logic [31:0] w_data_reg;
   logic w_strb_reg;
   logic w_have_reg;
   logic ext_edge;
   logic [SRC_N-1:0] events;
   logic [SRC_N-1:0] pending;
   logic pick_valid;
   logic [1:0] pick_idx;
   logic accept;
   logic wr_fire;
   logic wr_a;
   logic wr_b;
   logic wr_e;
   logic [7:0] wbyte;

   // ----------------------------------------
   // sources and priority
   // ----------------------------------------
   ext_edge_detect u_edge (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .pin_in(ext_pin_in),
      .mode_in(edge_reg),
      .edge_out(ext_edge)
   );

   // event vector in priority order
   assign events = {tb_event_in, adc_done_in, t0_overflow_in, ext_edge};
   assign pending = flag_reg & en_reg;

   irq_priority_pick u_pick (
      .req_in(pending),
      .valid_out(pick_valid),
      .idx_out(pick_idx)
   );

   // acceptance only at a boundary, gated by global enable and stack room
   assign accept = ce_in && cpu_req_in.boundary && state_reg == ST_IDLE && gie_reg &&
      pick_valid && !cpu_req_in.stack_full;

   // ----------------------------------------
   // register file
   // ----------------------------------------
   assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
   assign wr_a = wr_fire && w_strb_reg && aw_addr_reg == OFS_CTRL_A;
   assign wr_b = wr_fire && w_strb_reg && aw_addr_reg == OFS_CTRL_B;
   assign wr_e = wr_fire && w_strb_reg && aw_addr_reg == OFS_EDGE;
   assign wbyte = w_data_reg[7:0];

   // register read decode
   function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a);
      read_word = '0;
      unique case (a)
         OFS_CTRL_A: begin
            read_word[A_GIE] = gie_reg;
            read_word[A_EXT_EN] = en_reg[SRC_EXT];
            read_word[A_T0_EN] = en_reg[SRC_T0];
            read_word[A_ADC_EN] = en_reg[SRC_ADC];
            read_word[A_EXT_F] = flag_reg[SRC_EXT];
            read_word[A_T0_F] = flag_reg[SRC_T0];
            read_word[A_ADC_F] = flag_reg[SRC_ADC];
         end
         OFS_CTRL_B: begin
            read_word[B_TB_EN] = en_reg[SRC_TB];
            read_word[B_TB_F] = flag_reg[SRC_TB];
         end
         OFS_EDGE: read_word[EDGE_HI:EDGE_LO] = edge_reg;
         OFS_STAT: begin
            read_word[ST_STATE_LSB +: 2] = state_reg;
            read_word[ST_SRC_LSB +: 2] = src_reg;
            read_word[ST_WAKE_BIT] = wake_out;
         end
         default: read_word = '0;
      endcase
   endfunction

   // address is mapped
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = a == OFS_CTRL_A || a == OFS_CTRL_B || a == OFS_EDGE || a == OFS_STAT;
   endfunction

   // flags: software write, service clear of the external flag only, then hardware set wins
   always_comb begin
      flag_next = flag_reg;
      if (wr_a) begin
         flag_next[SRC_EXT] = wbyte[A_EXT_F];
         flag_next[SRC_T0] = wbyte[A_T0_F];
         flag_next[SRC_ADC] = wbyte[A_ADC_F];
      end
      if (wr_b) begin
         flag_next[SRC_TB] = wbyte[B_TB_F];
      end
      if (accept && pick_idx == SRC_EXT) begin
         flag_next[SRC_EXT] = 1'b0;
      end
      flag_next = flag_next | events;
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         flag_reg <= '0;
      end else if (ce_in) begin
         flag_reg <= flag_next;
      end
   end

   // enables, global enable and edge select
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         gie_reg <= 1'b0;
         en_reg <= '0;
         edge_reg <= EDGE_OFF;
      end else if (ce_in) begin
         if (wr_a) begin
            gie_reg <= wbyte[A_GIE];
            en_reg[SRC_EXT] <= wbyte[A_EXT_EN];
            en_reg[SRC_T0] <= wbyte[A_T0_EN];
            en_reg[SRC_ADC] <= wbyte[A_ADC_EN];
         end
         if (wr_b) begin
            en_reg[SRC_TB] <= wbyte[B_TB_EN];
         end
         if (wr_e) begin
            edge_reg <= edge_mode_t'(wbyte[EDGE_HI:EDGE_LO]);
         end
         if (accept) begin
            gie_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // service sequence
   // ----------------------------------------
   // accept, optional wake slot, push, vector load: one boundary each
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= ST_IDLE;
         src_reg <= SRC_EXT;
      end else if (ce_in && cpu_req_in.boundary) begin
         unique case (state_reg)
            ST_IDLE: begin
               if (accept) begin
                  src_reg <= pick_idx;
                  state_reg <= cpu_req_in.sleep ? ST_WAKE : ST_PUSH;
               end
            end
            ST_WAKE: state_reg <= ST_PUSH;
            ST_PUSH: state_reg <= ST_LOAD;
            ST_LOAD: state_reg <= ST_IDLE;
         endcase
      end
   end

   // cpu strobes, one cycle each
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         cpu_ctl_out <= '0;
      end else if (ce_in) begin
         cpu_ctl_out.push <= cpu_req_in.boundary && state_reg == ST_PUSH;
         cpu_ctl_out.load <= cpu_req_in.boundary && state_reg == ST_LOAD;
         cpu_ctl_out.pop <= cpu_req_in.boundary && cpu_req_in.interrupt_return_instruction;
         if (cpu_req_in.boundary && state_reg == ST_PUSH) begin
            cpu_ctl_out.push_addr <= cpu_req_in.pc;
         end
         if (cpu_req_in.boundary && state_reg == ST_LOAD) begin
            cpu_ctl_out.vector_addr <= vector_of(src_reg);
         end
      end
   end

   // wake request for sleep logic
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wake_out <= 1'b0;
      end else if (ce_in) begin
         wake_out <= |pending;
      end
   end

   // ----------------------------------------
   // axi4-lite write channel
   // ----------------------------------------
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_have_reg <= 1'b0;
         w_data_reg <= '0;
         w_strb_reg <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (ce_in) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // axi4-lite read channel
   // ----------------------------------------
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (ce_in) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= read_word(s_axi_araddr);
            s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   chk_no_global: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !gie_reg |-> !accept) else $error("accepted with global enable clear");
   chk_enable_gate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      accept |-> en_reg[pick_idx] && flag_reg[pick_idx]) else $error("disabled source taken");
   chk_stack_full: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      cpu_req_in.stack_full |-> !accept) else $error("accepted with stack full");
   chk_gie_cleared: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      accept |=> !gie_reg) else $error("global enable not cleared on entry");
   chk_flag_set: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      ce_in && t0_overflow_in |=> flag_reg[SRC_T0]) else $error("timer flag lost");
   chk_ext_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      accept && pick_idx == SRC_EXT && !ext_edge |=> !flag_reg[SRC_EXT])
      else $error("external flag not cleared");
   chk_push_addr: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      ce_in && cpu_req_in.boundary && state_reg == ST_PUSH
      |=> cpu_ctl_out.push && cpu_ctl_out.push_addr == $past(cpu_req_in.pc))
      else $error("push missing or wrong address");
   chk_load_vector: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      cpu_ctl_out.load |-> cpu_ctl_out.vector_addr == vector_of(src_reg) && !cpu_ctl_out.push)
      else $error("wrong vector loaded");
   chk_push_then_load: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      cpu_ctl_out.push && ce_in |-> state_reg == ST_LOAD) else $error("push not followed by load");
   chk_wake_slot: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      accept && cpu_req_in.sleep |=> state_reg == ST_WAKE) else $error("no wake slot");
   chk_pop_interrupt_return_instruction: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      ce_in && cpu_req_in.boundary && cpu_req_in.interrupt_return_instruction |=> cpu_ctl_out.pop)
      else $error("return did not pop");
endmodule

// ==== dv/cpu_core_model.sv ====
// behavioural cpu core: instruction boundaries, program counter and return stack
`timescale 1ns/1ps
module cpu_core_model import irq_pkg::*; (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // bench controls
   input wire logic sleep_in,
   input wire logic full_in,
   input wire logic interrupt_return_instruction_in,
   // sequencer side
   input wire cpu_ctl_t ctl_in,
   output cpu_req_t req_out,
   // tallies for the bench
   output int pushes_out,
   output int loads_out,
   output int pops_out,
   output int bnd_out,
   output int load_bnd_out,
   output logic [PC_W-1:0] push_addr_out,
   output logic [PC_W-1:0] exp_pc_out
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [1:0] div_reg;
   logic [PC_W-1:0] pc_reg;
   logic [PC_W-1:0] bpc_reg;
   logic [PC_W-1:0] stack_reg [8];
   int sp;

   // boundary pulse every fourth cycle; stack reports full at depth eight
   assign req_out = {div_reg == 2'h3, sleep_in, full_in | (sp == 8), interrupt_return_instruction_in, pc_reg};

   // pc steps per instruction, jumps on load, returns on pop
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         div_reg <= 2'h0;
         pc_reg <= 13'h0100;
         bpc_reg <= 13'h0000;
         bnd_out <= 0;
      end else begin
         div_reg <= div_reg + 2'h1;
         if (div_reg == 2'h3) begin
            pc_reg <= pc_reg + 13'h0001;
            bpc_reg <= pc_reg;
            bnd_out <= bnd_out + 1;
         end
         if (ctl_in.load) pc_reg <= ctl_in.vector_addr;
         if (ctl_in.pop) pc_reg <= stack_reg[sp - 1];
      end
   end

   // stack storage, no reset needed
   always_ff @(posedge clk_sys_in) begin
      if (ctl_in.push) stack_reg[sp[2:0]] <= ctl_in.push_addr;
   end

   // stack pointer and transfer tallies
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         sp <= 0;
         pushes_out <= 0;
         loads_out <= 0;
         pops_out <= 0;
         load_bnd_out <= 0;
         push_addr_out <= 13'h0000;
         exp_pc_out <= 13'h0000;
      end else begin
         if (ctl_in.push) begin
            sp <= sp + 1;
            pushes_out <= pushes_out + 1;
            push_addr_out <= ctl_in.push_addr;
            exp_pc_out <= bpc_reg;
         end
         if (ctl_in.pop) begin
            sp <= sp - 1;
            pops_out <= pops_out + 1;
         end
         if (ctl_in.load) begin
            loads_out <= loads_out + 1;
            load_bnd_out <= bnd_out;
         end
      end
   end
endmodule

// ==== dv/test_mcu_interrupt_sequencer.sv ====
// self-checking bench for the interrupt sequencer
`timescale 1ns/1ps
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fails++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_mcu_interrupt_sequencer import irq_pkg::*; ;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic ext_pin = 1'b0, t0_ev = 1'b0, adc_ev = 1'b0, tb_ev = 1'b0;
   logic sleep = 1'b0, full = 1'b0, interrupt_return_instruction = 1'b0, ce = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, wake;
   logic [1:0] bresp, rresp, rs;
   cpu_req_t req;
   cpu_ctl_t ctl;
   int pushes, loads, pops, bnd, load_bnd, ev, p0, l0;
   logic [PC_W-1:0] push_addr, exp_pc;
   int fails = 0, checks_done = 0, cyc = 0;

   mcu_interrupt_sequencer DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce),
      .ext_pin_in(ext_pin), .t0_overflow_in(t0_ev), .adc_done_in(adc_ev), .tb_event_in(tb_ev),
      .cpu_req_in(req), .cpu_ctl_out(ctl), .wake_out(wake),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   cpu_core_model cpu (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .sleep_in(sleep),
      .full_in(full), .interrupt_return_instruction_in(interrupt_return_instruction), .ctl_in(ctl), .req_out(req), .pushes_out(pushes),
      .loads_out(loads), .pops_out(pops), .bnd_out(bnd), .load_bnd_out(load_bnd),
      .push_addr_out(push_addr), .exp_pc_out(exp_pc));

   // 200 mhz clock
   initial begin
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // hang guard
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         give_verdict();
      end
   end

   // bready and rready stay high after a transfer; only the hang guard ends a wait
   task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk_sys_in);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk_sys_in);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      axi_wr(a, d, rs);
      `CHECK(rs, RESP_OKAY)
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      axi_rd(a, rd, rs);
      `CHECK({rs, rd}, {RESP_OKAY, 24'h0, exp})
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask

   task automatic wait_bnd();
      int n;
      n = 0;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (req.boundary !== 1'b1 && n < 10);
   endtask

   // event pulse just after a boundary edge
   task automatic fire(input logic [2:0] m);
      wait_bnd();
      ev = bnd;
      {tb_ev, adc_ev, t0_ev} <= m;
      @(posedge clk_sys_in);
      {tb_ev, adc_ev, t0_ev} <= 3'h0;
   endtask

   task automatic wait_load();
      int n;
      n = 0;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (loads == l0 && n < 100);
      if (n >= 100) fails++;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic s_reset();
      `CHECK({ctl, wake}, 30'h0)
      rd_chk(OFS_CTRL_A, 8'h00);
      rd_chk(OFS_CTRL_B, 8'h00);
      rd_chk(OFS_EDGE, 8'h00);
      axi_rd(8'h10, rd, rs);
      `CHECK({rs, rd}, {RESP_SLVERR, 32'h0})
      axi_wr(8'h10, 8'hff, rs);
      `CHECK(rs, RESP_SLVERR)
      // an event while the clock enable is low must not be taken
      ce <= 1'b0;
      t0_ev <= 1'b1;
      @(posedge clk_sys_in);
      ce <= 1'b1;
      t0_ev <= 1'b0;
      rd_chk(OFS_CTRL_A, 8'h00);
      $display("reset test done");
   endtask

   task automatic s_gate();
      wr(OFS_CTRL_A, 8'h01);
      p0 = pushes;
      fire(3'b001);
      repeat (3) wait_bnd();
      `CHECK(pushes, p0)
      rd_chk(OFS_CTRL_A, 8'h21);
      wr(OFS_CTRL_A, 8'h04);
      fire(3'b001);
      rd_chk(OFS_CTRL_A, 8'h24);
      repeat (3) wait_bnd();
      `CHECK(pushes, p0)
      $display("gating test done");
   endtask

   task automatic s_service();
      wr(OFS_CTRL_A, 8'h05);
      p0 = pushes;
      l0 = loads;
      fire(3'b001);
      wait_load();
      `CHECK(load_bnd, ev + 4)
      `CHECK(ctl.vector_addr, 13'h0008)
      `CHECK(push_addr, exp_pc)
      `CHECK(pushes - p0, 1)
      `CHECK(loads - l0, 1)
      rd_chk(OFS_CTRL_A, 8'h24);
      $display("service test done");
   endtask

   task automatic s_priority();
      wr(OFS_CTRL_A, 8'h0e);
      wr(OFS_CTRL_B, 8'h01);
      wr(OFS_EDGE, 8'h40);
      ext_pin <= 1'b1;
      fire(3'b111);
      cycles(4);
      rd_chk(OFS_CTRL_A, 8'h7e);
      for (int i = 0; i < 4; i++) begin
         axi_rd(OFS_CTRL_A, rd, rs);
         l0 = loads;
         wr(OFS_CTRL_A, rd[7:0] | 8'h01);
         wait_load();
         `CHECK(ctl.vector_addr, 13'(4 + 4 * i))
         axi_rd(OFS_CTRL_A, rd, rs);
         `CHECK(rd[7:0] & 8'h11, 8'h00)
         if (i == 1) wr(OFS_CTRL_A, rd[7:0] & 8'hdf);
         if (i == 2) wr(OFS_CTRL_A, rd[7:0] & 8'hbf);
         if (i == 3) wr(OFS_CTRL_B, 8'h01);
      end
      $display("priority test done");
   endtask

   task automatic s_edges();
      for (int m = 0; m < 4; m++) begin
         ext_pin <= 1'b0;
         cycles(6);
         wr(OFS_EDGE, {2'(m), 6'h0});
         wr(OFS_CTRL_A, 8'h00);
         ext_pin <= 1'b1;
         cycles(6);
         rd_chk(OFS_CTRL_A, {3'h0, m[0], 4'h0});
         wr(OFS_CTRL_A, 8'h00);
         ext_pin <= 1'b0;
         cycles(6);
         rd_chk(OFS_CTRL_A, {3'h0, m[1], 4'h0});
      end
      $display("edge test done");
   endtask

   task automatic s_stack();
      full <= 1'b1;
      wr(OFS_EDGE, 8'h40);
      wr(OFS_CTRL_A, 8'h03);
      p0 = pushes;
      l0 = loads;
      ext_pin <= 1'b1;
      repeat (4) wait_bnd();
      `CHECK(pushes, p0)
      rd_chk(OFS_CTRL_A, 8'h13);
      full <= 1'b0;
      wait_load();
      `CHECK(ctl.vector_addr, 13'h0004)
      p0 = pops;
      interrupt_return_instruction <= 1'b1;
      wait_bnd();
      interrupt_return_instruction <= 1'b0;
      cycles(2);
      `CHECK(pops - p0, 1)
      $display("stack test done");
   endtask

   task automatic s_sleep();
      sleep <= 1'b1;
      wr(OFS_CTRL_A, 8'h05);
      l0 = loads;
      fire(3'b001);
      cycles(2);
      `CHECK(wake, 1'b1)
      wait_load();
      `CHECK(load_bnd, ev + 5)
      // status: idle, last source timer, wake still raised by the pending flag
      axi_rd(OFS_STAT, rd, rs);
      `CHECK({rs, rd}, {RESP_OKAY, 32'h00000110})
      sleep <= 1'b0;
      $display("sleep test done");
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      @(posedge clk_sys_in);
      s_reset();
      s_gate();
      s_service();
      s_priority();
      s_edges();
      s_stack();
      s_sleep();
      give_verdict();
   end
endmodule
